// ---- design/remote_i2c_alias_remap_mailbox.sv ----
// module: alias decoders for remote slots 2 to 7, address remap and two mailbox bytes
// Overview of operation
// - each alias slot holds a seven-bit alias in bits 7:1, compared to incoming address
// - on a match, the paired remote target address replaces the incoming address
// - an alias field of zero never matches
// - decode remote targets through alias slots; this block covers slots two to seven
// - two mailbox bytes are plain read/write storage with no side effects
// - remote target address is seven bits and replaces alias before forwarding
`timescale 1ns/10ps
module remote_i2c_alias_remap_mailbox #(
  parameter int unsigned NUM_SLOTS = alias_remap_pkg::NUM_SLOTS
) (
  // clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_reset_n,
  // register port from the I2C target logic
  input  wire alias_remap_pkg::reg_req_type      i_reg_req,
  output logic [7:0]                             o_reg_rdata,
  output logic                                   o_reg_rvalid,
  output logic                                   o_reg_hit,
  // physical remote addresses of slots 2 to 7, held outside
  input  wire logic [NUM_SLOTS*7-1:0]            i_remote_target_address,
  // incoming transaction address from the local I2C master
  input  wire alias_remap_pkg::tgt_req_type      i_tgt_req,
  // re-addressed transaction toward the control channel
  output alias_remap_pkg::tgt_fwd_type           o_tgt_fwd,
  output logic                                   o_tgt_done
);

  // six slots is all the register map can hold; other counts are refused at build
  if (NUM_SLOTS != alias_remap_pkg::NUM_SLOTS) begin : g_bad_slot_count
    $error("slot count must match the register map");
  end

  // the slot number travels in three bits, so the last slot must stay below eight
  if (alias_remap_pkg::FIRST_SLOT + NUM_SLOTS > 8) begin : g_bad_slot_field
    $error("slot numbers do not fit the forwarded slot field");
  end

  // the decode counts up from the first slot offset, so the offsets must be contiguous
  if (alias_remap_pkg::ALIAS_SLOT_7_OFFSET - alias_remap_pkg::ALIAS_SLOT_2_OFFSET !=
      8'(NUM_SLOTS - 1)) begin : g_bad_slot_span
    $error("alias slot offsets are not contiguous");
  end

  // the alias field must be exactly as wide as a target address
  if (alias_remap_pkg::ALIAS_FIELD_MSB - alias_remap_pkg::ALIAS_FIELD_LSB + 1 !=
      alias_remap_pkg::TGT_W) begin : g_bad_field
    $error("alias field width differs from the target address width");
  end

  // the reserved bit must come out of reset low
  if (alias_remap_pkg::ALIAS_SLOT_RESET[alias_remap_pkg::RESERVED_BIT] != 1'b0) begin : g_bad_rsv
    $error("reserved alias bit must reset to zero");
  end

  // one select line per register: alias slots first, then the two message bytes
  localparam int unsigned NUM_REGS = NUM_SLOTS + 2;
  localparam int unsigned SEL_A    = NUM_SLOTS;
  localparam int unsigned SEL_B    = NUM_SLOTS + 1;

  // one-hot decode of a register offset, shared by the write and the read path
  function automatic logic [NUM_REGS-1:0] reg_select(input logic [7:0] addr);
    logic [NUM_REGS-1:0] sel;
    sel = '0;
    for (int r = 0; r < NUM_SLOTS; r++) begin
      if (addr == alias_remap_pkg::ALIAS_SLOT_2_OFFSET + 8'(r)) begin
        sel[r] = 1'b1;
      end
    end
    if (addr == alias_remap_pkg::MESSAGE_BYTE_A_OFFSET) begin
      sel[SEL_A] = 1'b1;
    end
    if (addr == alias_remap_pkg::MESSAGE_BYTE_B_OFFSET) begin
      sel[SEL_B] = 1'b1;
    end
    return sel;
  endfunction

  logic [7:0]           alias_slot_q [NUM_SLOTS];
  logic [7:0]           message_byte_a_q;
  logic [7:0]           message_byte_b_q;
  logic [6:0]           remote_address [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] hit;
  logic [NUM_REGS-1:0]  wr_sel;
  logic [NUM_REGS-1:0]  rd_sel;
  logic [7:0]           rdata_d;
  logic                 rhit_d;

  // strobes gate the decode, so an idle port selects nothing
  assign wr_sel = i_reg_req.write ? reg_select(i_reg_req.addr) : '0;
  assign rd_sel = i_reg_req.read ? reg_select(i_reg_req.addr) : '0;

  // alias slot storage and one comparator per slot
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          alias_slot_q[g] <= alias_remap_pkg::ALIAS_SLOT_RESET;
        end else if (wr_sel[g]) begin
          alias_slot_q[g] <= i_reg_req.wdata;
        end
      end

      // slot g+2 takes its physical address from lane g
      assign remote_address[g] = i_remote_target_address[g*7 +: 7];

      alias_slot_match u_match (
        .i_alias_slot (alias_slot_q[g]),
        .i_target     (i_tgt_req.target),
        .o_hit        (hit[g])
      );
    end
  endgenerate

  // message byte a: storage only, it steers nothing
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      message_byte_a_q <= alias_remap_pkg::MESSAGE_BYTE_A_RESET;
    end else if (wr_sel[SEL_A]) begin
      message_byte_a_q <= i_reg_req.wdata;
    end
  end

  // message byte b: like a, only its value after reset differs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      message_byte_b_q <= alias_remap_pkg::MESSAGE_BYTE_B_RESET;
    end else if (wr_sel[SEL_B]) begin
      message_byte_b_q <= i_reg_req.wdata;
    end
  end

  // read mux; a foreign offset answers zero with the hit flag low
  always_comb begin
    rdata_d = 8'h00;
    rhit_d  = 1'b0;
    // offsets are distinct, so at most one select is high
    for (int r = 0; r < NUM_SLOTS; r++) begin
      if (rd_sel[r]) begin
        rdata_d = alias_slot_q[r];
        rhit_d  = 1'b1;
      end
    end
    if (rd_sel[SEL_A]) begin
      rdata_d = message_byte_a_q;
      rhit_d  = 1'b1;
    end
    if (rd_sel[SEL_B]) begin
      rdata_d = message_byte_b_q;
      rhit_d  = 1'b1;
    end
  end

  // answer one cycle after the strobe; a read beside a write sees the old value
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_req.read;
    end
  end

  // read data stands for the answer cycle only and is zero otherwise
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= rdata_d;
    end
  end

  // hit flag tells a mapped offset from a foreign one
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_hit <= 1'b0;
    end else begin
      o_reg_hit <= rhit_d;
    end
  end

  // lowest slot wins if software programs the same alias twice
  logic [6:0] remap_addr;
  logic [2:0] remap_slot;
  logic       any_hit;

  always_comb begin
    remap_addr = 7'h00;
    remap_slot = 3'h0;
    any_hit    = 1'b0;
    for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
      if (hit[s]) begin
        remap_addr = remote_address[s];
        remap_slot = 3'(s + alias_remap_pkg::FIRST_SLOT);
        any_hit    = 1'b1;
      end
    end
  end

  // a miss still answers, so the master side never waits on a lookup
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tgt_done <= 1'b0;
    end else begin
      o_tgt_done <= i_tgt_req.valid;
    end
  end

  // the result holds until the next request, so the channel may take it late
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tgt_fwd <= '0;
    end else if (i_tgt_req.valid) begin
      o_tgt_fwd.forward <= any_hit;
      o_tgt_fwd.target  <= remap_addr;
      o_tgt_fwd.rnw     <= i_tgt_req.rnw;
      o_tgt_fwd.slot    <= remap_slot;
    end
  end

endmodule // remote_i2c_alias_remap_mailbox

// ---- design/alias_remap_pkg.sv ----
// package: register map, field layout and carrier types of the alias remap block
package alias_remap_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TGT_W  = 7;

  localparam logic [7:0] ALIAS_SLOT_2_OFFSET   = 8'h12;
  localparam logic [7:0] ALIAS_SLOT_3_OFFSET   = 8'h13;
  localparam logic [7:0] ALIAS_SLOT_4_OFFSET   = 8'h14;
  localparam logic [7:0] ALIAS_SLOT_5_OFFSET   = 8'h15;
  localparam logic [7:0] ALIAS_SLOT_6_OFFSET   = 8'h16;
  localparam logic [7:0] ALIAS_SLOT_7_OFFSET   = 8'h17;
  localparam logic [7:0] MESSAGE_BYTE_A_OFFSET = 8'h18;
  localparam logic [7:0] MESSAGE_BYTE_B_OFFSET = 8'h19;

  localparam int unsigned FIRST_SLOT = 2;
  localparam int unsigned NUM_SLOTS  = 6;

  localparam int unsigned ALIAS_FIELD_MSB = 7;
  localparam int unsigned ALIAS_FIELD_LSB = 1;
  localparam int unsigned RESERVED_BIT    = 0;

  localparam logic [7:0] ALIAS_SLOT_RESET     = 8'h00;
  localparam logic [7:0] MESSAGE_BYTE_A_RESET = 8'h00;
  localparam logic [7:0] MESSAGE_BYTE_B_RESET = 8'h01;

  localparam logic [6:0] ALIAS_DISABLED = 7'h00;

  // register port request
  typedef struct packed {
    logic             write;
    logic             read;
    logic [7:0]       addr;
    logic [7:0]       wdata;
  } reg_req_type;

  // incoming transaction target
  typedef struct packed {
    logic             valid;
    logic [6:0]       target;
    logic             rnw;
  } tgt_req_type;

  // result of the alias lookup
  typedef struct packed {
    logic             forward;
    logic [6:0]       target;
    logic             rnw;
    logic [2:0]       slot;
  } tgt_fwd_type;

endpackage

// ---- design/alias_slot_match.sv ----
// module: one alias slot comparator
`timescale 1ns/10ps
module alias_slot_match (
  // slot configuration
  input  wire logic [7:0] i_alias_slot,
  // incoming address
  input  wire logic [6:0] i_target,
  // result
  output logic            o_hit
);

  logic [6:0] alias_address_field;

  // bit 0 is reserved and never enters the compare
  assign alias_address_field = i_alias_slot[alias_remap_pkg::ALIAS_FIELD_MSB:
                                            alias_remap_pkg::ALIAS_FIELD_LSB];

  // a zero field must not match even an all-zero general call address
  assign o_hit = (alias_address_field != alias_remap_pkg::ALIAS_DISABLED) &&
                 (alias_address_field == i_target);

endmodule // alias_slot_match

// ---- testbench/alias_remap_assertions.sv ----
// checker: port timing and remap checks
`timescale 1ns/10ps
module alias_remap_assertions #(parameter int unsigned NUM_SLOTS = 6) (
  // watched ports
  input wire logic                         i_clk,
  input wire logic                         i_reset_n,
  input wire alias_remap_pkg::reg_req_type i_reg_req,
  input wire logic [7:0]                   o_reg_rdata,
  input wire logic                         o_reg_rvalid,
  input wire logic                         o_reg_hit,
  input wire logic [NUM_SLOTS*7-1:0]       i_remote_target_address,
  input wire alias_remap_pkg::tgt_req_type i_tgt_req,
  input wire alias_remap_pkg::tgt_fwd_type o_tgt_fwd,
  input wire logic                         o_tgt_done
);
  logic       map_rd;
  logic [6:0] phys;
  // an out-of-range slot gives an unknown here, which fails the remap check
  assign map_rd = i_reg_req.read && i_reg_req.addr inside {[8'h12:8'h19]};
  assign phys = i_remote_target_address[(int'(o_tgt_fwd.slot) - 2) * 7 +: 7];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  AST_RD: assert property (i_reg_req.read |=> o_reg_rvalid) else $error("no answer");
  AST_MAP: assert property (map_rd |=> o_reg_hit) else $error("no hit");
  AST_MISS: assert property (i_reg_req.read && !map_rd |=> !o_reg_hit && !o_reg_rdata)
    else $error("unmapped read");
  AST_DONE: assert property (i_tgt_req.valid |=> o_tgt_done) else $error("no done");
  AST_IDLE: assert property (!i_tgt_req.valid |=> !o_tgt_done) else $error("stray done");
  AST_HOLD: assert property (!i_tgt_req.valid |=> $stable(o_tgt_fwd)) else $error("moved");
  AST_REMAP: assert property (o_tgt_done && o_tgt_fwd.forward |-> o_tgt_fwd.target == phys)
    else $error("bad remap");
  AST_ZERO: assert property (o_tgt_done && !o_tgt_fwd.forward |-> !o_tgt_fwd.target)
    else $error("miss target");
endmodule // alias_remap_assertions
bind remote_i2c_alias_remap_mailbox alias_remap_assertions #(.NUM_SLOTS(NUM_SLOTS)) chk_inst (.*);

// ---- testbench/remote_target_model.sv ----
// model: far-side holder of the physical remote addresses
`timescale 1ns/10ps
module remote_target_model (
  // addresses in, addresses out
  input  wire logic        i_clk,
  input  wire logic [41:0] i_cfg,
  output logic      [41:0] o_remote_target_address
);
  always_ff @(posedge i_clk) o_remote_target_address <= i_cfg;
endmodule // remote_target_model

// ---- testbench/tb.sv ----
// testbench: register, mailbox and alias lookup scenarios
`timescale 1ns/10ps
module tb;
  alias_remap_pkg::reg_req_type i_reg_req = '0;
  alias_remap_pkg::tgt_req_type i_tgt_req = '0;
  alias_remap_pkg::tgt_fwd_type o_tgt_fwd;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [7:0]  o_reg_rdata;
  logic        o_reg_rvalid, o_reg_hit, o_tgt_done;
  logic [41:0] cfg, i_remote_target_address;
  logic [7:0]  rm [8'h12:8'h19];
  logic [8:0]  rq [$];
  logic [11:0] fq [$];
  logic [31:0] seed = 32'h0000001F;
  int          error_cnt = 0;
  int          cmp_count = 0;
  initial forever #2 i_clk = ~i_clk;
  remote_target_model remote_target_model_inst (
    .i_clk                   (i_clk),
    .i_cfg                   (cfg),
    .o_remote_target_address (i_remote_target_address)
  );
  remote_i2c_alias_remap_mailbox remote_i2c_alias_remap_mailbox_inst (
    .i_clk                   (i_clk),
    .i_reset_n               (i_reset_n),
    .i_reg_req               (i_reg_req),
    .o_reg_rdata             (o_reg_rdata),
    .o_reg_rvalid            (o_reg_rvalid),
    .o_reg_hit               (o_reg_hit),
    .i_remote_target_address (i_remote_target_address),
    .i_tgt_req               (i_tgt_req),
    .o_tgt_fwd               (o_tgt_fwd),
    .o_tgt_done              (o_tgt_done)
  );
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(negedge i_clk) begin
    if (o_reg_rvalid === 1'b1) chk({3'h0, o_reg_hit, o_reg_rdata}, {3'h0, rq.pop_front()});
    if (o_tgt_done === 1'b1) chk(o_tgt_fwd, fq.pop_front());
  end
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_tgt_req.valid = 1'b0;
    i_reg_req = '{w, !w, a, d};
    if (w && a inside {[8'h12:8'h19]}) rm[a] = d;
    if (!w) rq.push_back((a inside {[8'h12:8'h19]}) ? {1'b1, rm[a]} : 9'h000);
  endtask
  // lowest slot wins, so scan downward and let later hits overwrite
  task automatic lk(input logic [6:0] t);
    logic [11:0] e;
    e = {8'h00, seed[9], 3'h0};
    for (int s = 7; s >= 2; s--)
      if (t != 7'h00 && rm[8'h10 + s][7:1] == t) e = {1'b1, cfg[(s - 2) * 7 +: 7], e[3], 3'(s)};
    @(negedge i_clk);
    i_reg_req = '0;
    i_tgt_req = '{1'b1, t, e[3]};
    fq.push_back(e);
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    cfg = 42'({xs(), xs()});
    foreach (rm[a]) rm[a] = (a == 8'h19) ? 8'h01 : 8'h00;
    repeat (10) @(negedge i_clk);
    i_reset_n = 1'b1;
    // reset reads, back-to-back writes, then readback, 0x11 and 0x1A unmapped
    for (int p = 0; p < 30; p++) op(p inside {[10:19]}, 8'(8'h11 + p % 10), 8'(xs()));
    $display("test registers done");
    for (int s = 2; s <= 7; s++) op(1'b1, 8'(8'h10 + s), 8'(xs()) | 8'h01);
    for (int s = 2; s <= 7; s++) lk(rm[8'h10 + s][7:1]);
    for (int i = 0; i < 16; i++) lk(7'(xs()));
    $display("test remap done");
    op(1'b1, 8'h12, 8'h01);
    op(1'b1, 8'h18, 8'hA5);
    op(1'b0, 8'h18, 8'h00);
    lk(7'h00);
    lk(rm[8'h13][7:1]);
    $display("test disabled slot done");
    @(negedge i_clk);
    i_tgt_req = '0;
    for (int i = 0; i < 20 && rq.size() + fq.size() > 0; i++) @(negedge i_clk);
    if (rq.size() + fq.size() > 0) begin
      error_cnt++;
      $display("[ERR] %0t results missing at end of run", $time);
    end
    report_and_stop();
  end
endmodule // tb
